//--- include/counter_array_pkg.sv
package counter_array_pkg;

   localparam logic [7:0] CONTROL_ADDR = 8'hD8;
   localparam logic [7:0] MODE_ADDR = 8'hD9;
   localparam logic [7:0] PWM_CONFIG_ADDR = 8'hDF;

   localparam logic [7:0] MODE_RESET = 8'h40;
   localparam logic [7:0] PWM_CONFIG_RESET = 8'h00;
   localparam logic CONTROL_RUN_RESET = 1'h0;

   localparam int CONTROL_FLAG_BIT = 7;
   localparam int CONTROL_RUN_BIT = 6;
   localparam int MODE_LOCK_BIT = 5;
   localparam int PWM_FLAG_BIT = 5;
   localparam int MODE_IDLE_BIT = 7;
   localparam int MODE_ENABLE_BIT = 6;
   localparam int MODE_TB_LSB = 1;
   localparam int MODE_IRQ_BIT = 0;
   localparam int PWM_RELOAD_BIT = 7;
   localparam int PWM_IRQ_BIT = 6;
   localparam int PWM_LENGTH_LSB = 0;

   localparam logic [2:0] TB_SYS_DIV12 = 3'h0;
   localparam logic [2:0] TB_SYS_DIV4 = 3'h1;
   localparam logic [2:0] TB_TIMER0 = 3'h2;
   localparam logic [2:0] TB_EXT_FALL = 3'h3;
   localparam logic [2:0] TB_SYS = 3'h4;
   localparam logic [2:0] TB_EXT_DIV8 = 3'h5;
   localparam logic [2:0] TB_RTC_DIV8 = 3'h6;

   localparam int DIV_SYS12 = 12;
   localparam int DIV_SYS4 = 4;
   localparam int DIV_SLOW8 = 8;
   localparam int DIV_WIDTH = 4;

   localparam int CHANNELS = 6;
   localparam logic [15:0] COUNTER_MAX = 16'hFFFF;

   typedef struct packed
   {
      logic idle_suspend;
      logic watchdog_enable;
      logic watchdog_lock;
      logic unused;
      logic [2:0] timebase_select;
      logic overflow_irq_enable;
   } mode_type;

   typedef struct packed
   {
      logic autoreload_select;
      logic cycle_overflow_irq_enable;
      logic cycle_overflow_flag;
      logic [2:0] unused;
      logic [1:0] cycle_length_select;
   } pwm_config_type;

   typedef struct packed
   {
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_request_type;

endpackage : counter_array_pkg

//--- core/sync_fall_detect.sv
`timescale 1ns/10ps
module sync_fall_detect
(
   input wire logic clock,
   input wire logic rst,
   input wire logic async_in,
   output logic fall_pulse
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // Two-stage synchroniser, third stage for edge
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stage1_reg <= 1'b1;
         stage2_reg <= 1'b1;
         stage3_reg <= 1'b1;
      end
      else
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   assign fall_pulse = stage3_reg & ~stage2_reg;
endmodule : sync_fall_detect

//--- core/tick_divider.sv
`timescale 1ns/10ps
module tick_divider
#(
   parameter int DIVISOR = 4,
   parameter int WIDTH = 4
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic tick_in,
   output logic tick_out
);
   localparam logic [WIDTH-1:0] LAST = WIDTH'(DIVISOR - 1);
   logic [WIDTH-1:0] count_reg;

   // Pulse on every DIVISOR-th input tick
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         count_reg <= '0;
      else if (tick_in)
         count_reg <= (count_reg == LAST) ? '0 : count_reg + WIDTH'(1);
   end

   assign tick_out = tick_in & (count_reg == LAST);
endmodule : tick_divider

//--- core/counter_array_config.sv
`timescale 1ns/10ps
//Behaviour
//[RL1] Idle-suspend set halts the counter array while the CPU idles.
//[RL2] Watchdog-enable hands module 5 over to watchdog duty.
//[RL3] Once locked, watchdog-enable cannot be cleared until system reset.
//[RL4] While watchdog-enable is set, other mode bits ignore writes; the lock bit is still set by a write with bit 5 high.
//[RL5] Timebase codes 000, 001, 010, 100 pick sysclk/12, /4, timer0, sysclk.
//[RL6] Code 011 counts falling edges of external count input, at most sysclk/4.
//[RL7] Codes 101 and 110 count external and RTC clocks divided by 8, synchronised.
//[RL8] Overflow flag with its enable raises the counter array interrupt.
//[RL9] Mode bit 4 reads zero and ignores writes.
//[RL10] Auto-reload select steers capture/compare accesses to reload registers.
//[RL11] Reload values apply only in 9, 10 and 11-bit PWM.
//[RL12] Cycle-overflow flag with its enable raises the interrupt.
//[RL13] Cycle-overflow flag sets on carry out of bit 8..11 per length select.
//[RL14] Hardware or software sets cycle-overflow flag; only software clears it.
//[RL15] Cycle length select 00..11 gives 8..11-bit PWM cycles.
//[RL16] Cycle length applies to non-16-bit PWM channels only.
//[RL17] PWM config bits 4 to 2 read zero, writes discarded.
//[RL18] Counter wrap from FFFF to 0000 sets overflow flag; software clears.
//[RL19] Counter advances only while run-control is set.
//[RL20] External count input synchronised in two stages, falling edge one-cycle pulse.
//[RL21] Interrupt request is OR of every enabled source.
module counter_array_config
   import counter_array_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire sfr_request_type sfr_request,
   output logic [7:0] sfr_rdata,
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   input wire logic external_clock,
   input wire logic rtc_clock,
   input wire logic module_irq,
   input wire logic [CHANNELS-1:0] channel_pwm_enable,
   input wire logic [CHANNELS-1:0] channel_pwm16,
   output logic [15:0] counter_value,
   output logic counter_tick,
   output logic module5_watchdog,
   output logic autoreload_select,
   output logic [1:0] cycle_length_select,
   output logic [CHANNELS-1:0] channel_cycle_end,
   output logic [CHANNELS-1:0] channel_reload_active,
   output logic irq
);
   mode_type mode_reg;
   pwm_config_type pwm_reg;
   logic counter_run_reg;
   logic counter_overflow_flag_reg;
   logic [15:0] counter_reg;
   logic [7:0] rdata_reg;
   logic write_control;
   logic write_mode;
   logic write_pwm;
   logic ext_fall;
   logic ext_clock_fall;
   logic rtc_fall;
   logic sys_div12;
   logic sys_div4;
   logic ext_div8;
   logic rtc_div8;
   logic timebase_tick;
   logic run_active;
   logic advance;
   logic counter_wrap;
   logic cycle_wrap;
   logic [10:0] cycle_mask;

   assign write_control = sfr_request.write && sfr_request.addr == CONTROL_ADDR;
   assign write_mode = sfr_request.write && sfr_request.addr == MODE_ADDR;
   assign write_pwm = sfr_request.write && sfr_request.addr == PWM_CONFIG_ADDR;

   // External count input edge
   sync_fall_detect ext_count_sync
   (
      .clock(clock),
      .rst(rst),
      .async_in(external_count_input),
      .fall_pulse(ext_fall)
   ); // RL20 RL6

   sync_fall_detect ext_clock_sync
   (
      .clock(clock),
      .rst(rst),
      .async_in(external_clock),
      .fall_pulse(ext_clock_fall)
   ); // RL7

   sync_fall_detect rtc_clock_sync
   (
      .clock(clock),
      .rst(rst),
      .async_in(rtc_clock),
      .fall_pulse(rtc_fall)
   ); // RL7

   tick_divider #(.DIVISOR(DIV_SYS12), .WIDTH(DIV_WIDTH)) div_sys12
   (
      .clock(clock),
      .rst(rst),
      .tick_in(1'b1),
      .tick_out(sys_div12)
   );

   tick_divider #(.DIVISOR(DIV_SYS4), .WIDTH(DIV_WIDTH)) div_sys4
   (
      .clock(clock),
      .rst(rst),
      .tick_in(1'b1),
      .tick_out(sys_div4)
   );

   tick_divider #(.DIVISOR(DIV_SLOW8), .WIDTH(DIV_WIDTH)) div_ext8
   (
      .clock(clock),
      .rst(rst),
      .tick_in(ext_clock_fall),
      .tick_out(ext_div8)
   ); // RL7

   tick_divider #(.DIVISOR(DIV_SLOW8), .WIDTH(DIV_WIDTH)) div_rtc8
   (
      .clock(clock),
      .rst(rst),
      .tick_in(rtc_fall),
      .tick_out(rtc_div8)
   ); // RL7

   // Timebase selection
   always_comb
   begin
      case (mode_reg.timebase_select)
         TB_SYS_DIV12: timebase_tick = sys_div12; // RL5
         TB_SYS_DIV4: timebase_tick = sys_div4; // RL5
         TB_TIMER0: timebase_tick = timer0_overflow; // RL5
         TB_EXT_FALL: timebase_tick = ext_fall; // RL6
         TB_SYS: timebase_tick = 1'b1; // RL5
         TB_EXT_DIV8: timebase_tick = ext_div8; // RL7
         TB_RTC_DIV8: timebase_tick = rtc_div8; // RL7
         default: timebase_tick = 1'b0;
      endcase
   end

   assign run_active = counter_run_reg && !(mode_reg.idle_suspend && cpu_idle); // RL19 RL1
   assign advance = run_active && timebase_tick;
   assign counter_wrap = advance && counter_reg == COUNTER_MAX;

   // Cycle length mask
   always_comb
   begin
      case (pwm_reg.cycle_length_select)
         2'h0: cycle_mask = 11'h0FF; // RL15
         2'h1: cycle_mask = 11'h1FF; // RL15
         2'h2: cycle_mask = 11'h3FF; // RL15
         2'h3: cycle_mask = 11'h7FF; // RL15
         default: cycle_mask = 11'h0FF;
      endcase
   end

   assign cycle_wrap = advance && ((counter_reg[10:0] & cycle_mask) == cycle_mask); // RL13

   // Counter
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         counter_reg <= 16'h0000;
      else if (advance)
         counter_reg <= counter_reg + 16'h0001; // RL19
   end

   // Control register: run bit and overflow flag
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         counter_run_reg <= CONTROL_RUN_RESET;
         counter_overflow_flag_reg <= 1'b0;
      end
      else
      begin
         if (write_control)
            counter_run_reg <= sfr_request.wdata[CONTROL_RUN_BIT];
         if (counter_wrap)
            counter_overflow_flag_reg <= 1'b1; // RL18
         else if (write_control)
            counter_overflow_flag_reg <= sfr_request.wdata[CONTROL_FLAG_BIT];
      end
   end

   // Mode register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         mode_reg <= mode_type'(MODE_RESET);
      else if (write_mode)
      begin
         if (sfr_request.wdata[MODE_LOCK_BIT])
            mode_reg.watchdog_lock <= 1'b1; // RL3
         if (!mode_reg.watchdog_lock)
            mode_reg.watchdog_enable <= sfr_request.wdata[MODE_ENABLE_BIT]; // RL3 RL2
         if (!mode_reg.watchdog_enable)
         begin
            mode_reg.idle_suspend <= sfr_request.wdata[MODE_IDLE_BIT]; // RL4
            mode_reg.timebase_select <= sfr_request.wdata[MODE_TB_LSB +: 3]; // RL4
            mode_reg.overflow_irq_enable <= sfr_request.wdata[MODE_IRQ_BIT]; // RL4
         end
         mode_reg.unused <= 1'b0; // RL9
      end
   end

   // PWM configuration register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pwm_reg <= pwm_config_type'(PWM_CONFIG_RESET);
      else
      begin
         if (write_pwm)
         begin
            pwm_reg.autoreload_select <= sfr_request.wdata[PWM_RELOAD_BIT];
            pwm_reg.cycle_overflow_irq_enable <= sfr_request.wdata[PWM_IRQ_BIT];
            pwm_reg.cycle_length_select <= sfr_request.wdata[PWM_LENGTH_LSB +: 2];
            pwm_reg.unused <= 3'h0; // RL17
         end
         if (cycle_wrap)
            pwm_reg.cycle_overflow_flag <= 1'b1; // RL13 RL14
         else if (write_pwm)
            pwm_reg.cycle_overflow_flag <= sfr_request.wdata[PWM_FLAG_BIT]; // RL14
      end
   end

   // Read data
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata_reg <= 8'h00;
      else
      begin
         case (sfr_request.addr)
            CONTROL_ADDR: rdata_reg <= {counter_overflow_flag_reg, counter_run_reg, 6'h00};
            MODE_ADDR: rdata_reg <= mode_reg; // RL9
            PWM_CONFIG_ADDR: rdata_reg <= pwm_reg; // RL17
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata = rdata_reg;
   assign counter_value = counter_reg;
   assign counter_tick = advance;
   assign module5_watchdog = mode_reg.watchdog_enable; // RL2
   assign autoreload_select = pwm_reg.autoreload_select; // RL10
   assign cycle_length_select = pwm_reg.cycle_length_select; // RL15
   assign channel_cycle_end = {CHANNELS{cycle_wrap}} & channel_pwm_enable & ~channel_pwm16; // RL16
   assign channel_reload_active = (pwm_reg.cycle_length_select != 2'h0) ?
      (channel_pwm_enable & ~channel_pwm16) : {CHANNELS{1'b0}}; // RL11
   assign irq = (counter_overflow_flag_reg && mode_reg.overflow_irq_enable) // RL8 RL21
      || (pwm_reg.cycle_overflow_flag && pwm_reg.cycle_overflow_irq_enable) // RL12
      || module_irq;

   // Checks
   a_idle_halts: assert property (@(posedge clock) disable iff (rst) // RL1
      mode_reg.idle_suspend && cpu_idle |=> counter_reg == $past(counter_reg))
      else $error("counter moved while idle-suspended");
   a_lock_holds: assert property (@(posedge clock) disable iff (rst) // RL3
      mode_reg.watchdog_lock && mode_reg.watchdog_enable |=> mode_reg.watchdog_enable && mode_reg.watchdog_lock)
      else $error("locked watchdog enable was cleared");
   a_mode_frozen: assert property (@(posedge clock) disable iff (rst) // RL4
      mode_reg.watchdog_enable |=> mode_reg.timebase_select == $past(mode_reg.timebase_select)
         && mode_reg.idle_suspend == $past(mode_reg.idle_suspend)
         && mode_reg.overflow_irq_enable == $past(mode_reg.overflow_irq_enable))
      else $error("mode bits changed under watchdog");
   a_sys_count: assert property (@(posedge clock) disable iff (rst) // RL5
      run_active && mode_reg.timebase_select == TB_SYS |=> counter_reg == $past(counter_reg) + 16'h0001)
      else $error("undivided timebase did not advance");
   a_div4_rate: assert property (@(posedge clock) disable iff (rst) // RL5
      advance && mode_reg.timebase_select == TB_SYS_DIV4 && !write_mode
         |=> !advance [*3])
      else $error("divide-by-four tick too fast");
   a_overflow_irq: assert property (@(posedge clock) disable iff (rst) // RL8
      counter_overflow_flag_reg && mode_reg.overflow_irq_enable |-> irq)
      else $error("overflow interrupt missing");
   a_unused_zero: assert property (@(posedge clock) disable iff (rst) // RL9
      !mode_reg.unused && pwm_reg.unused == 3'h0)
      else $error("unused bits not zero");
   a_cycle_set: assert property (@(posedge clock) disable iff (rst) // RL13
      cycle_wrap |=> pwm_reg.cycle_overflow_flag && irq == pwm_reg.cycle_overflow_irq_enable || module_irq
         || counter_overflow_flag_reg)
      else $error("cycle overflow not flagged");
   a_cycle_sticky: assert property (@(posedge clock) disable iff (rst) // RL14
      pwm_reg.cycle_overflow_flag && !write_pwm |=> pwm_reg.cycle_overflow_flag)
      else $error("cycle overflow cleared by hardware");
   a_wrap_flag: assert property (@(posedge clock) disable iff (rst) // RL18
      counter_wrap |=> counter_overflow_flag_reg && counter_reg == 16'h0000)
      else $error("wrap did not set overflow flag");
   a_stopped_holds: assert property (@(posedge clock) disable iff (rst) // RL19
      !counter_run_reg |=> counter_reg == $past(counter_reg))
      else $error("counter moved while stopped");
   c_ext_edge: cover property (@(posedge clock) disable iff (rst)
      mode_reg.timebase_select == TB_EXT_FALL && advance);
   c_wrap: cover property (@(posedge clock) disable iff (rst) counter_wrap);
   c_lock: cover property (@(posedge clock) disable iff (rst) write_mode && mode_reg.watchdog_lock);
endmodule : counter_array_config

//--- verification/test_counter_array_config.sv
`timescale 1ns/10ps
module test_counter_array_config
   import counter_array_pkg::*;
();
   logic clock;
   logic rst;
   sfr_request_type req;
   logic [7:0] sfr_rdata;
   logic cpu_idle;
   logic timer0_overflow;
   logic external_count_input;
   logic external_clock;
   logic rtc_clock;
   logic module_irq;
   logic [CHANNELS-1:0] channel_pwm_enable;
   logic [CHANNELS-1:0] channel_pwm16;
   logic [15:0] counter_value;
   logic module5_watchdog;
   logic autoreload_select;
   logic [1:0] cycle_length_select;
   logic [CHANNELS-1:0] channel_reload_active;
   logic counter_tick;
   logic [CHANNELS-1:0] channel_cycle_end;
   logic irq;
   int failures;
   int cmp_count;
   int tick_count = 0;
   int cycle_end_count = 0;
   int ends_mark;
   logic rd_req;
   logic rd_d = 1'h0;
   logic [7:0] exp_d;
   logic [7:0] exp_q[$];
   logic [31:0] seed;
   // Timebase table: code, idle suspend, cycles driven, tick bounds
   logic [2:0] t_code[10] = '{TB_SYS, TB_SYS_DIV4, TB_SYS_DIV12, TB_TIMER0, TB_EXT_FALL, TB_EXT_DIV8,
                              TB_RTC_DIV8, 3'h7, TB_SYS, TB_SYS};
   logic t_idl[10] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
   int t_cyc[10] = '{12, 72, 232, 64, 64, 64, 64, 64, 12, 12};
   int t_lo[10] = '{19, 19, 18, 16, 16, 2, 2, 0, 0, 19};
   int t_hi[10] = '{23, 22, 22, 16, 16, 2, 2, 0, 0, 23};

   counter_array_config counter_array_config_i
   (
      .clock(clock),
      .rst(rst),
      .sfr_request(req),
      .sfr_rdata(sfr_rdata),
      .cpu_idle(cpu_idle),
      .timer0_overflow(timer0_overflow),
      .external_count_input(external_count_input),
      .external_clock(external_clock),
      .rtc_clock(rtc_clock),
      .module_irq(module_irq),
      .channel_pwm_enable(channel_pwm_enable),
      .channel_pwm16(channel_pwm16),
      .counter_value(counter_value),
      .counter_tick(counter_tick),
      .module5_watchdog(module5_watchdog),
      .autoreload_select(autoreload_select),
      .cycle_length_select(cycle_length_select),
      .channel_cycle_end(channel_cycle_end),
      .channel_reload_active(channel_reload_active),
      .irq(irq)
   );

   initial
   begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic check_val(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check_val

   task automatic check_range(input string n, input int lo, input int hi, input logic [15:0] g);
      cmp_count++;
      if ((g >= lo && g <= hi) !== 1'h1)
      begin
         failures++;
         $display("[FAIL] %s expected %0d..%0d seen %h", n, lo, hi, g);
      end
   endtask : check_range

   task automatic do_reset;
      rst = 1'h1;
      repeat (16) @(negedge clock);
      rst = 1'h0;
   endtask : do_reset

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      req.write = 1'h1;
      req.addr = a;
      req.wdata = d;
      @(negedge clock);
      req.write = 1'h0;
   endtask : sfr_write

   task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      req.addr = a;
      rd_req = 1'h1;
      exp_q.push_back(e);
      @(negedge clock);
      rd_req = 1'h0;
   endtask : sfr_read

   task automatic wait_ge(input logic [15:0] target);
      int i;
      for (i = 0; i < 70000; i++)
      begin
         if (counter_value >= target)
            break;
         @(negedge clock);
      end
      if (i == 70000)
      begin
         failures++;
         $display("[FAIL] counter wait expected %h seen %h", target, counter_value);
         tally_and_finish();
      end
   endtask : wait_ge

   task automatic measure(input int k);
      logic [15:0] start;
      logic [15:0] held;
      int ticks;
      sfr_write(MODE_ADDR, {t_idl[k], 3'h0, t_code[k], 1'h0});
      cpu_idle = (k >= 8);
      start = counter_value;
      ticks = tick_count;
      sfr_write(CONTROL_ADDR, 8'h40);
      for (int i = 0; i < t_cyc[k]; i++)
      begin
         @(negedge clock);
         timer0_overflow = (t_code[k] == TB_TIMER0) && (i % 4 == 1);
         external_count_input = (t_code[k] == TB_EXT_FALL) ? ~i[1] : 1'h1;
         external_clock = (t_code[k] == TB_EXT_DIV8) ? ~i[1] : 1'h1;
         rtc_clock = (t_code[k] == TB_RTC_DIV8) ? ~i[1] : 1'h1;
      end
      @(negedge clock);
      timer0_overflow = 1'h0;
      external_count_input = 1'h1;
      external_clock = 1'h1;
      rtc_clock = 1'h1;
      repeat (7) @(negedge clock);
      sfr_write(CONTROL_ADDR, 8'h00);
      repeat (4) @(negedge clock);
      check_range("counter delta", t_lo[k], t_hi[k], counter_value - start);
      check_range("counter_tick count", t_lo[k], t_hi[k], 16'(tick_count - ticks));
      held = counter_value;
      repeat (10) @(negedge clock);
      check_val("counter held", held, counter_value);
   endtask : measure

   // Pulse outputs counted; every cycle end must name the non-16-bit PWM channels
   always @(posedge clock)
   begin
      if (counter_tick === 1'h1)
         tick_count <= tick_count + 1;
      if (channel_cycle_end !== 6'h00)
      begin
         cycle_end_count <= cycle_end_count + 1;
         check_val("channel_cycle_end", 16'h001A, channel_cycle_end);
      end
   end

   // Read results are compared in the order they were requested
   always @(posedge clock)
   begin
      rd_d <= rd_req;
      if (rd_d)
      begin
         exp_d = exp_q.pop_front();
         check_val("sfr_rdata", exp_d, sfr_rdata);
      end
   end

   initial
   begin
      failures = 0;
      cmp_count = 0;
      seed = 32'h524AD6E8;
      rst = 1'h1;
      rd_req = 1'h0;
      req = '0;
      cpu_idle = 1'h0;
      timer0_overflow = 1'h0;
      external_count_input = 1'h1;
      external_clock = 1'h1;
      rtc_clock = 1'h1;
      module_irq = 1'h0;
      channel_pwm_enable = 6'h1E;
      channel_pwm16 = 6'h05;
      do_reset();
      sfr_read(MODE_ADDR, 8'h40);
      sfr_read(PWM_CONFIG_ADDR, 8'h00);
      sfr_read(CONTROL_ADDR, 8'h00);
      sfr_read(8'hA0, 8'h00);
      check_val("watchdog", 1'h1, module5_watchdog);
      check_val("irq", 1'h0, irq);
      $display("done reset values");
      sfr_write(MODE_ADDR, 8'hCF);
      sfr_read(MODE_ADDR, 8'h40);
      sfr_write(MODE_ADDR, 8'h00);
      sfr_read(MODE_ADDR, 8'h00);
      check_val("watchdog", 1'h0, module5_watchdog);
      sfr_write(MODE_ADDR, 8'h9F);
      sfr_read(MODE_ADDR, 8'h8F);
      sfr_write(MODE_ADDR, 8'h00);
      $display("done mode protection");
      for (int r = 0; r < 4; r++)
      begin
         repeat (8) seed = lfsr_next(seed);
         sfr_write(PWM_CONFIG_ADDR, seed[7:0]);
         sfr_read(PWM_CONFIG_ADDR, seed[7:0] & 8'hE3);
         check_val("autoreload_select", seed[7], autoreload_select);
         check_val("cycle_length_select", seed[1:0], cycle_length_select);
      end
      for (int c = 0; c < 4; c++)
      begin
         sfr_write(PWM_CONFIG_ADDR, 8'(c));
         check_val("reload_active", (c == 0) ? 6'h00 : 6'h1A, channel_reload_active);
      end
      sfr_write(PWM_CONFIG_ADDR, 8'h00);
      $display("done pwm config");
      for (int k = 0; k < 10; k++)
         measure(k);
      cpu_idle = 1'h0;
      $display("done timebase");
      sfr_write(PWM_CONFIG_ADDR, 8'h03);
      ends_mark = cycle_end_count;
      sfr_write(MODE_ADDR, 8'h08);
      sfr_write(CONTROL_ADDR, 8'h40);
      wait_ge(16'h0700);
      sfr_write(CONTROL_ADDR, 8'h00);
      sfr_read(PWM_CONFIG_ADDR, 8'h03);
      sfr_write(CONTROL_ADDR, 8'h40);
      wait_ge(16'h0802);
      sfr_write(CONTROL_ADDR, 8'h00);
      sfr_read(PWM_CONFIG_ADDR, 8'h23);
      check_val("cycle end pulses", 16'h0001, 16'(cycle_end_count - ends_mark));
      check_val("irq", 1'h0, irq);
      sfr_write(PWM_CONFIG_ADDR, 8'h63);
      check_val("irq", 1'h1, irq);
      sfr_write(PWM_CONFIG_ADDR, 8'h43);
      check_val("irq", 1'h0, irq);
      sfr_read(PWM_CONFIG_ADDR, 8'h43);
      $display("done cycle overflow");
      sfr_write(PWM_CONFIG_ADDR, 8'h00);
      sfr_write(MODE_ADDR, 8'h09);
      sfr_write(CONTROL_ADDR, 8'h40);
      wait_ge(16'hFFFF);
      sfr_read(CONTROL_ADDR, 8'hC0);
      check_val("irq", 1'h1, irq);
      sfr_write(CONTROL_ADDR, 8'h80);
      sfr_write(MODE_ADDR, 8'h08);
      check_val("irq", 1'h0, irq);
      module_irq = 1'h1;
      @(negedge clock);
      check_val("irq", 1'h1, irq);
      module_irq = 1'h0;
      sfr_write(CONTROL_ADDR, 8'h00);
      sfr_read(CONTROL_ADDR, 8'h00);
      $display("done counter overflow");
      sfr_write(MODE_ADDR, 8'h60);
      sfr_read(MODE_ADDR, 8'h60);
      sfr_write(MODE_ADDR, 8'h0F);
      sfr_read(MODE_ADDR, 8'h60);
      check_val("watchdog", 1'h1, module5_watchdog);
      @(negedge clock);
      do_reset();
      sfr_read(MODE_ADDR, 8'h40);
      sfr_write(MODE_ADDR, 8'h00);
      sfr_read(MODE_ADDR, 8'h00);
      $display("done watchdog lock");
      repeat (4) @(negedge clock);
      tally_and_finish();
   end
endmodule : test_counter_array_config
